// *** src/sot_otp_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - enter opcode selects otp area for reads/programs
// - exit opcode returns addressing to main array
// - no status/security writes during otp access
// - locked otp area: reads only, no program/erase
// - security register readable anytime, streamed continuously
// - bit0 read-only factory lock indicator
// - bit1 customer lock, sticky, freezes otp
// - security write needs no write enable
// - cs must rise on byte boundary
// - otp mode blocks main array writes
// - otp addresses split serial field/user space
module sot_otp_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic quad_instruction_mode_i,
  input wire logic factory_lock_i,
  input wire logic customer_lock_bit_i,
  input wire sot_pkg::sot_req_t req_i,
  output sot_pkg::sot_grant_t grant_o,
  output logic otp_mode_o,
  output logic [7:0] sec_reg_o,
  output logic lock_prog_o
);

  // ---------------- link domain (sck) ----------------
  // cs high clears the frame flag, read hold and pin drivers; count and shifter hold their
  // last frame so the core side can read them once cs has settled high
  logic in_frame;
  logic frame_tog;
  logic [6:0] bit_cnt;
  logic [15:0] shifter;
  logic [1:0] lock_s1;
  logic [1:0] lock_s2;
  logic read_hold;
  logic cust_lock;
  logic fact_lock;
  logic [2:0] pin_sync;

  // pins pass two core flops; the mode level is not latched per frame, so it must
  // stay steady across a frame for the link to use it from the first edge
  sot_sync2 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_i(core_clk_i),
    .d_i({quad_instruction_mode_i, customer_lock_bit_i, factory_lock_i}),
    .q_o(pin_sync)
  );

  wire quad_lvl = pin_sync[2];
  wire [6:0] step = quad_lvl ? sot_pkg::STEP_QUAD : sot_pkg::STEP_SPI;
  wire [15:0] next_shift_spi = {shifter[14:0], io_i[0]};
  wire [15:0] next_shift_quad = {shifter[11:0], io_i};
  wire [15:0] next_shifter = quad_lvl ? next_shift_quad : next_shift_spi;
  wire cnt_sat = bit_cnt > sot_pkg::BITS_SAT;
  // step back one byte when full, so the read-out keeps its bit phase
  wire [6:0] cnt_wrap = bit_cnt + step - sot_pkg::BITS_OPCODE;
  wire [6:0] cnt_inc = bit_cnt + step;
  wire [6:0] next_bit_cnt = !in_frame ? step : (cnt_sat ? cnt_wrap : cnt_inc);

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // sck stands still during reset, so the toggle is cleared directly
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      frame_tog <= 1'b0;
    end else if (!in_frame) begin
      frame_tog <= ~frame_tog;
    end
  end

  always_ff @(posedge sck_i) begin
    bit_cnt <= next_bit_cnt;
    shifter <= next_shifter;
  end

  // lock bits are quasi-static levels, brought over by two flops
  always_ff @(posedge sck_i) begin
    lock_s1 <= {cust_lock, fact_lock};
    lock_s2 <= lock_s1;
  end

  // read-out of the security register on the falling edge
  wire [7:0] sec_link = {6'h00, lock_s2};
  wire read_cmd = in_frame && (bit_cnt >= sot_pkg::BITS_OPCODE) &&
                  (shifter[7:0] == sot_pkg::OP_SEC_READ || read_hold);
  wire [2:0] out_pos = 3'(bit_cnt - sot_pkg::BITS_OPCODE);
  wire out_bit = sec_link[3'h7 - out_pos];
  wire [3:0] out_nib = out_pos[2] ? sec_link[3:0] : sec_link[7:4];
  wire [3:0] next_io = quad_lvl ? out_nib : {2'b00, out_bit, 1'b0};
  wire [3:0] next_oe = !read_cmd ? 4'h0 : (quad_lvl ? 4'hF : 4'h2);

  // once the opcode has been seen, keep streaming regardless of shifted data
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      read_hold <= 1'b0;
    end else if (bit_cnt == sot_pkg::BITS_OPCODE && shifter[7:0] == sot_pkg::OP_SEC_READ) begin
      read_hold <= 1'b1;
    end
  end

  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else begin
      io_o <= next_io;
      io_oe_o <= next_oe;
    end
  end

  // ---------------- core domain ----------------
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tog_s1;
  logic tog_s2;
  logic tog_seen;
  logic otp_mode;
  logic load_pend;

  always_ff @(posedge core_clk_i) begin
    cs_s1 <= cs_n_i;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    tog_s1 <= frame_tog;
    tog_s2 <= tog_s1;
  end

  // a frame ends when cs has risen and a new frame toggle has arrived;
  // a cs pulse without clocks carries no command
  wire frame_end = cs_s2 && !cs_s3 && (tog_s2 != tog_seen);
  wire len_opcode = bit_cnt == sot_pkg::BITS_OPCODE;
  wire len_write = bit_cnt == sot_pkg::BITS_OPC_DATA;
  wire [7:0] op_short = shifter[7:0];
  wire [7:0] op_long = shifter[15:8];
  wire [7:0] wr_data = shifter[7:0];
  wire otp_locked = cust_lock || fact_lock;

  wire do_enter = frame_end && len_opcode && op_short == sot_pkg::OP_OTP_ENTER;
  wire do_exit = frame_end && len_opcode && op_short == sot_pkg::OP_OTP_EXIT;
  // no write-enable latch is consulted here
  wire sec_wr = frame_end && len_write && op_long == sot_pkg::OP_SEC_WRITE;
  wire sec_wr_ok = sec_wr && !otp_mode && !cust_lock;
  wire set_lock = sec_wr_ok && wr_data[sot_pkg::SEC_CUST_BIT];

  wire next_otp_mode = do_enter ? 1'b1 : (do_exit ? 1'b0 : otp_mode);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tog_seen <= 1'b0;
      otp_mode <= 1'b0;
      load_pend <= 1'b1;
      lock_prog_o <= 1'b0;
    end else begin
      if (frame_end) begin
        tog_seen <= tog_s2;
      end
      otp_mode <= next_otp_mode;
      load_pend <= 1'b0;
      lock_prog_o <= set_lock;
    end
  end

  // nonvolatile cells are copied in after reset release
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cust_lock <= 1'b0;
      fact_lock <= 1'b0;
    end else if (load_pend) begin
      cust_lock <= pin_sync[1];
      fact_lock <= pin_sync[0];
    end else if (set_lock) begin
      cust_lock <= 1'b1;
    end
  end

  // access verdicts for the main command path
  wire status_wr = req_i.wr_status1 || req_i.wr_status2;
  wire any_write = req_i.prog || req_i.erase;
  wire serial_hit = req_i.addr <= sot_pkg::OTP_SERIAL_LAST;
  wire in_otp = req_i.addr <= sot_pkg::OTP_USER_LAST;
  wire user_hit = in_otp && !serial_hit;
  sot_pkg::sot_grant_t next_grant;

  always_comb begin
    next_grant = '0;
    next_grant.otp_select = otp_mode;
    next_grant.status_wr_ok = status_wr && !otp_mode;
    next_grant.array_wr_ok = any_write && !otp_mode;
    next_grant.otp_wr_ok = any_write && otp_mode && !otp_locked && in_otp;
    next_grant.serial_hit = otp_mode && serial_hit;
    next_grant.user_hit = otp_mode && user_hit;
    next_grant.addr_fault = otp_mode && !in_otp;
    next_grant.otp_addr = req_i.addr[sot_pkg::OTP_ADDR_W-1:0];
  end

  wire [7:0] next_sec = {sot_pkg::SEC_RESERVED_VAL[7:2], cust_lock, fact_lock};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      grant_o <= '0;
      otp_mode_o <= 1'b0;
      sec_reg_o <= sot_pkg::SEC_RESERVED_VAL;
    end else begin
      grant_o <= next_grant;
      otp_mode_o <= next_otp_mode;
      sec_reg_o <= next_sec;
    end
  end

endmodule

// two-flop synchroniser for slow levels entering a clock domain
module sot_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule

// *** src/sot_pkg.sv ***
package sot_pkg;

  // command opcodes
  localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
  localparam logic [7:0] OP_SEC_READ = 8'h2B;
  localparam logic [7:0] OP_SEC_WRITE = 8'h2F;

  // frame lengths, count limit and per-clock steps in bits
  localparam logic [6:0] BITS_OPCODE = 7'h08;
  localparam logic [6:0] BITS_OPC_DATA = 7'h10;
  localparam logic [6:0] BITS_SAT = 7'h7B;
  localparam logic [6:0] STEP_SPI = 7'h01;
  localparam logic [6:0] STEP_QUAD = 7'h04;

  // security register layout
  localparam int SEC_FACTORY_BIT = 0;
  localparam int SEC_CUST_BIT = 1;
  localparam logic [7:0] SEC_RESERVED_VAL = 8'h00;

  // otp address map
  localparam logic [23:0] OTP_SERIAL_LAST = 24'h00_000F;
  localparam logic [23:0] OTP_USER_LAST = 24'h00_01FF;
  localparam int OTP_ADDR_W = 9;

  // access request from the main command path
  typedef struct packed {
    logic wr_status1;
    logic wr_status2;
    logic prog;
    logic erase;
    logic [23:0] addr;
  } sot_req_t;

  // verdict and redirection toward the array
  typedef struct packed {
    logic otp_select;
    logic status_wr_ok;
    logic array_wr_ok;
    logic otp_wr_ok;
    logic serial_hit;
    logic user_hit;
    logic addr_fault;
    logic [OTP_ADDR_W-1:0] otp_addr;
  } sot_grant_t;

endpackage

// *** testbench/secured_otp_access_control_tb_top.sv ***
`timescale 1ns/1ps
module secured_otp_access_control_tb_top;
  typedef struct {logic [15:0] d; int n, w, r; logic [7:0] s;
    logic m, k; logic [23:0] a;} sot_row_t;
  sot_row_t rows[8] = '{
    '{16'h00B1,8,1,0,8'h00,1'b1,1'b1,24'h00_000F},
    '{16'h2F02,16,1,0,8'h00,1'b1,1'b1,24'h00_01FF},
    '{16'h00C1,8,4,0,8'h00,1'b0,1'b0,24'h00_0010},
    '{16'h1781,15,1,0,8'h00,1'b0,1'b0,24'h00_0010},
    '{16'h2FFF,16,4,0,8'h02,1'b0,1'b0,24'h00_0010},
    '{16'h002B,8,1,16,8'h02,1'b0,1'b0,24'h00_0010},
    '{16'h002B,8,4,8,8'h02,1'b0,1'b0,24'h00_0010},
    '{16'h00B1,8,4,0,8'h02,1'b1,1'b0,24'h00_0200}};
  logic core_clk_i, rst_i, q, fl, sck, cs_n, md, lp;
  logic cl = 1'b0;
  logic [3:0] hio, dio, oe;
  wire [3:0] wio = (dio & oe) | (hio & ~oe);
  logic [7:0] sec, rd;
  sot_pkg::sot_req_t req;
  sot_pkg::sot_grant_t gr;
  int num_errors = 0;
  int n_compared = 0;
  sot_host u_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio), .io_i(wio));
  sot_otp_ctrl u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
    .io_i(wio), .io_o(dio), .io_oe_o(oe), .quad_instruction_mode_i(q), .factory_lock_i(fl),
    .customer_lock_bit_i(cl), .req_i(req), .grant_o(gr), .otp_mode_o(md), .sec_reg_o(sec),
    .lock_prog_o(lp));
  // the cell keeps its one across resets
  always @(posedge core_clk_i) if (lp) cl <= 1'b1;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
  initial begin
    rst_i = 1'b1;
    q = 1'b0;
    fl = 1'b0;
    req = '0;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    foreach (rows[j]) begin
      q = (rows[j].w == 4);
      req = '{1'b1, 1'b0, 1'b1, 1'b0, rows[j].a};
      u_host.xfer(rows[j].d, rows[j].n, rows[j].w, rows[j].r, rd);
      repeat (8) @(negedge core_clk_i);
      chk({sec, rd}, {rows[j].s, rows[j].r > 0 ? rows[j].s : 8'h00});
      chk({13'h0000, md, gr.otp_wr_ok, gr.array_wr_ok},
        {13'h0000, rows[j].m, rows[j].k, !rows[j].m});
    end
    fl = 1'b1;
    rst_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk({7'h00, md, sec}, 16'h0003);
    final_report;
  end
endmodule

// *** testbench/sot_host.sv ***
`timescale 1ns/1ps
module sot_host (
  output logic sck_o = 1'b0,
  output logic cs_n_o = 1'b1,
  output logic [3:0] io_o = 4'h0,
  input logic [3:0] io_i
);
  // w is 1 line or 4 lines, msb first; clock stands still between frames
  task automatic xfer(input logic [15:0] d, input int n, w, r, output logic [7:0] q);
    q = 8'h00;
    #1.3 cs_n_o = 1'b0;
    for (int i = n - w; i >= 0; i -= w) begin
      io_o = (w == 4) ? d[i+:4] : {3'h0, d[i]};
      #62.5 sck_o = 1'b1;
      #62.5 sck_o = 1'b0;
    end
    for (int i = 0; i < r; i += w) begin
      #62.5 sck_o = 1'b1;
      q = (w == 4) ? {q[3:0], io_i} : {q[6:0], io_i[1]};
      #62.5 sck_o = 1'b0;
    end
    // select rises after the n sent and r read bits, off a byte only when asked
    #62.5 cs_n_o = 1'b1;
    io_o = ~io_o;
    #20;
  endtask
endmodule

// *** testbench/sot_otp_ctrl_properties.sv ***
`timescale 1ns/1ps
module sot_props (
  input logic core_clk_i,
  input logic rst_i,
  input sot_pkg::sot_req_t req_i,
  input sot_pkg::sot_grant_t grant_o,
  input logic otp_mode_o,
  input logic [7:0] sec_reg_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  a_reserved_zero: assert property (sec_reg_o[7:2] == 6'h00) else $error("reserved");
  a_lock_sticky: assert property (sec_reg_o[1] |=> sec_reg_o[1]) else $error("unlock");
  a_select_mode: assert property (!$past(rst_i) |->
    grant_o.otp_select == $past(otp_mode_o)) else $error("select");
  a_status_blocked: assert property (grant_o.otp_select |-> !grant_o.status_wr_ok)
    else $error("status");
  a_array_rule: assert property (!$past(rst_i) |-> grant_o.array_wr_ok ==
    (($past(req_i.prog) || $past(req_i.erase)) && !grant_o.otp_select)) else $error("array");
  a_locked_no_prog: assert property (sec_reg_o != 8'h00 && $past(sec_reg_o) != 8'h00 |->
    !grant_o.otp_wr_ok) else $error("locked");
  a_serial_hit: assert property (!$past(rst_i) && grant_o.otp_select |->
    grant_o.serial_hit == ($past(req_i.addr) <= sot_pkg::OTP_SERIAL_LAST)) else $error("serial");
  a_addr_fault: assert property (!$past(rst_i) && grant_o.otp_select |->
    grant_o.addr_fault == ($past(req_i.addr) > sot_pkg::OTP_USER_LAST)) else $error("fault");
endmodule
bind sot_otp_ctrl sot_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
  .grant_o(grant_o), .otp_mode_o(otp_mode_o), .sec_reg_o(sec_reg_o));
